// ==== gpio_port.sv ====
// ============================================================
// gpio_port: general digital i/o port with apb registers
// assumes pins pass through an external pad model using the enables
//
// Contract
// - direction bit one makes pin output
// - output pin driven to output value bit
// - pull-up follows pull-up enable bit
// - pull-up independent of direction, else hi-z
// - pins tri-state immediately on reset
// - writing one to pin input toggles output
// - break-before-make adds one tri-state cycle
// - one break-before-make enable per port
// - no tri-state cycle on output to input
// - pin input reads synchronized pin level
// - sync latch then register on rising edge
// - external change visible after half to 1.5 clocks
// - written value visible one clock later
// - sleep clamps input path to ground
// - interrupt-enabled pins bypass sleep clamp
// - clamp removal makes edge flag on wake
// - pull-ups disabled during reset
// - six registers, pin input read-only
`timescale 1ns/100ps
module gpio_port
   import gpio_port_pkg::*;
#(
   parameter int WIDTH = WIDTH_DEF
) (
   input wire logic SYS_CLK_I,
   input wire logic RESET_N_I,
   input wire logic PSEL_I,
   input wire logic PENABLE_I,
   input wire logic PWRITE_I,
   input wire logic [11:0] PADDR_I,
   input wire logic [31:0] PWDATA_I,
   input wire logic [3:0] PSTRB_I,
   output logic [31:0] PRDATA_O,
   output logic PREADY_O,
   output logic PSLVERR_O,
   input wire logic [WIDTH-1:0] PIN_I,
   output logic [WIDTH-1:0] PIN_O,
   output logic [WIDTH-1:0] PIN_OE_O,
   output logic [WIDTH-1:0] PULLUP_ON_O,
   input wire logic SLEEP_I,
   input wire logic [WIDTH-1:0] EXT_IRQ_ENABLE_I,
   output logic [WIDTH-1:0] WAKE_EDGE_FLAG_O
);
   // ============================================================
   // registers
   logic [WIDTH-1:0] direction_register;
   logic [WIDTH-1:0] output_value_register;
   logic [WIDTH-1:0] pullup_enable_register;
   logic break_before_make_enable;
   logic [WIDTH-1:0] edge_sense;
   logic [WIDTH-1:0] drive_enable;
   logic [WIDTH-1:0] sync_latch;
   logic [WIDTH-1:0] pin_input_register;
   logic [WIDTH-1:0] clamp_active;
   logic [WIDTH-1:0] clamped_in;
   logic wr_en;
   logic rd_hit;
   logic [3:0] ofs;
   logic known;
   logic low_lane;

   // apb decode: zero-wait, one word per register
   assign wr_en = PSEL_I & PENABLE_I & PWRITE_I;
   assign ofs = PADDR_I[3:0];
   assign low_lane = PSTRB_I[0];
   assign known = (PADDR_I[11:4] == 8'h00) || (PADDR_I == PORT_CONTROL_OFS)
      || (PADDR_I == SENSE_CONTROL_OFS);
   assign rd_hit = PSEL_I & ~PWRITE_I;
   assign PREADY_O = 1'b1;
   assign PSLVERR_O = PSEL_I & PENABLE_I & ~known;

   // ============================================================
   // configuration registers, cleared by reset
   always_ff @(posedge SYS_CLK_I) begin
      if (!RESET_N_I) begin
         direction_register <= '0;
         pullup_enable_register <= '0;
         break_before_make_enable <= 1'b0;
         edge_sense <= '0;
      end else if (wr_en && low_lane) begin
         if (PADDR_I[11:4] == 8'h00 && ofs == DIRECTION_OFS) begin
            direction_register <= PWDATA_I[WIDTH-1:0];
         end
         if (PADDR_I[11:4] == 8'h00 && ofs == PULLUP_ENABLE_OFS) begin
            pullup_enable_register <= PWDATA_I[WIDTH-1:0];
         end
         if (PADDR_I == PORT_CONTROL_OFS) begin
            break_before_make_enable <= PWDATA_I[BBM_BIT];
         end
         if (PADDR_I == SENSE_CONTROL_OFS) begin
            edge_sense <= PWDATA_I[WIDTH-1:0];
         end
      end
   end

   // output value: direct write, or toggle via pin input location
   always_ff @(posedge SYS_CLK_I) begin
      if (!RESET_N_I) begin
         output_value_register <= '0;
      end else if (wr_en && low_lane && PADDR_I[11:4] == 8'h00) begin
         if (ofs == OUTPUT_VALUE_OFS) begin
            output_value_register <= PWDATA_I[WIDTH-1:0];
         end else if (ofs == PIN_INPUT_OFS) begin
            output_value_register <= output_value_register
               ^ PWDATA_I[WIDTH-1:0];
         end
      end
   end

   // ============================================================
   // driver enable: lags a rising direction bit by one cycle in bbm
   always_ff @(posedge SYS_CLK_I) begin
      if (!RESET_N_I) begin
         drive_enable <= '0;
      end else begin
         drive_enable <= direction_register;
      end
   end

   // pad drive; reset forces tri-state and pull-ups off at once
   always_comb begin
      for (int i = 0; i < WIDTH; i++) begin
         PIN_O[i] = output_value_register[i];
         PIN_OE_O[i] = RESET_N_I & direction_register[i]
            & (~break_before_make_enable | drive_enable[i]);
         PULLUP_ON_O[i] = RESET_N_I & pullup_enable_register[i];
      end
   end

   // ============================================================
   // sleep clamp and synchronizer, two stages per pin
   assign clamp_active = {WIDTH{SLEEP_I}} & ~EXT_IRQ_ENABLE_I;
   assign clamped_in = PIN_I & ~clamp_active;

   genvar g;
   generate
      for (g = 0; g < WIDTH; g++) begin : g_sync
         // transparent while clock high, holds on falling edge
         always_latch begin
            if (SYS_CLK_I) begin
               sync_latch[g] = clamped_in[g];
            end
         end
      end
   endgenerate

   // second stage loaded on rising edge
   always_ff @(posedge SYS_CLK_I) begin
      if (!RESET_N_I) begin
         pin_input_register <= '0;
      end else begin
         pin_input_register <= sync_latch;
      end
   end

   // wake flag: clamp release on a high edge-sensed pin
   always_ff @(posedge SYS_CLK_I) begin
      if (!RESET_N_I) begin
         WAKE_EDGE_FLAG_O <= '0;
      end else begin
         WAKE_EDGE_FLAG_O <= ~pin_input_register & sync_latch
            & edge_sense & ~EXT_IRQ_ENABLE_I & ~clamp_active;
      end
   end

   // ============================================================
   // read data register
   always_ff @(posedge SYS_CLK_I) begin
      if (!RESET_N_I) begin
         PRDATA_O <= READ_ZERO;
      end else if (rd_hit && !PENABLE_I) begin
         PRDATA_O <= READ_ZERO;
         if (PADDR_I[11:4] == 8'h00) begin
            unique case (ofs)
               PIN_INPUT_OFS: PRDATA_O[WIDTH-1:0] <= pin_input_register;
               DIRECTION_OFS: PRDATA_O[WIDTH-1:0] <= direction_register;
               OUTPUT_VALUE_OFS: PRDATA_O[WIDTH-1:0] <= output_value_register;
               PULLUP_ENABLE_OFS: PRDATA_O[WIDTH-1:0] <= pullup_enable_register;
               default: PRDATA_O <= READ_ZERO;
            endcase
         end else if (PADDR_I == PORT_CONTROL_OFS) begin
            PRDATA_O[BBM_BIT] <= break_before_make_enable;
         end else if (PADDR_I == SENSE_CONTROL_OFS) begin
            PRDATA_O[WIDTH-1:0] <= edge_sense;
         end
      end
   end
endmodule : gpio_port

// ==== gpio_port_pkg.sv ====
// ============================================================
// gpio_port_pkg: register map and field constants for one port
// assumes a 32-bit apb slave with one aligned word per register
package gpio_port_pkg;
   localparam int WIDTH_DEF = 8;
   localparam logic [3:0] PIN_INPUT_OFS = 4'h0;
   localparam logic [3:0] DIRECTION_OFS = 4'h4;
   localparam logic [3:0] OUTPUT_VALUE_OFS = 4'h8;
   localparam logic [3:0] PULLUP_ENABLE_OFS = 4'hC;
   localparam logic [11:0] PORT_CONTROL_OFS = 12'h010;
   localparam logic [11:0] SENSE_CONTROL_OFS = 12'h014;
   localparam int BBM_BIT = 0;
   localparam logic [31:0] READ_ZERO = 32'h0000_0000;
endpackage : gpio_port_pkg

// ==== gpio_port_properties.sv ====
// checker: port-level assertions for gpio_port
// assumes one clock; writes commit at the access edge
`timescale 1ns/100ps
module gpio_port_properties
   import gpio_port_pkg::*;
#(parameter int WIDTH = WIDTH_DEF) (
   input wire logic SYS_CLK_I,
   input wire logic RESET_N_I,
   input wire logic PSEL_I,
   input wire logic PENABLE_I,
   input wire logic PWRITE_I,
   input wire logic [11:0] PADDR_I,
   input wire logic [31:0] PWDATA_I,
   input wire logic [3:0] PSTRB_I,
   input wire logic [WIDTH-1:0] PIN_O,
   input wire logic [WIDTH-1:0] PIN_OE_O,
   input wire logic [WIDTH-1:0] PULLUP_ON_O
);
   // ======================
   // write decode and a copy of the bbm enable
   logic bbm;
   wire wr = PSEL_I & PENABLE_I & PWRITE_I & PSTRB_I[0];
   wire [WIDTH-1:0] wd = PWDATA_I[WIDTH-1:0];
   wire w_dir = wr && PADDR_I == DIRECTION_OFS;
   always_ff @(posedge SYS_CLK_I)
      if (!RESET_N_I) bbm <= 1'b0;
      else if (wr && PADDR_I == PORT_CONTROL_OFS) bbm <= PWDATA_I[BBM_BIT];
   default clocking @(posedge SYS_CLK_I); endclocking
   default disable iff (!RESET_N_I);
   // new outputs stay released one cycle, then follow the write
   sequence late_on;
      (PIN_OE_O & ~$past(PIN_OE_O)) == 0 ##1 PIN_OE_O == $past(wd, 2);
   endsequence
   rst_off_a:
   assert property (disable iff (1'b0) !RESET_N_I |->
      PIN_OE_O == 0 && PULLUP_ON_O == 0) else $error("active in reset");
   rst_clr_a:
   assert property ($rose(RESET_N_I) |-> PIN_O == 0 && PULLUP_ON_O == 0)
      else $error("not cleared");
   out_a:
   assert property (wr && PADDR_I == OUTPUT_VALUE_OFS |=> PIN_O == $past(wd))
      else $error("output value");
   pull_a:
   assert property (wr && PADDR_I == PULLUP_ENABLE_OFS |=>
      PULLUP_ON_O == $past(wd)) else $error("pull-up");
   tog_a:
   assert property (wr && PADDR_I == PIN_INPUT_OFS |=>
      PIN_O == ($past(PIN_O) ^ $past(wd))) else $error("toggle");
   dir_a:
   assert property (w_dir && !bbm |=> PIN_OE_O == $past(wd))
      else $error("direction");
   bbm_a:
   assert property (w_dir && bbm |=> late_on) else $error("bbm delay");
   fall_a:
   assert property (w_dir |=> (PIN_OE_O & ~$past(wd)) == 0)
      else $error("late release");
endmodule : gpio_port_properties

// ==== pin_pads.sv ====
// board model: drives every pin the device releases
// assumes the device enables mark the driven pins
`timescale 1ns/100ps
module pin_pads (
   input wire logic [7:0] drv_i,
   input wire logic [7:0] oe_i,
   input wire logic [7:0] ext_i,
   output logic [7:0] pad_o
);
   // ======================
   // device level where enabled, board level elsewhere
   assign pad_o = oe_i & drv_i | ~oe_i & ext_i;
endmodule : pin_pads

// ==== test_gpio_port.sv ====
// bench for gpio_port: table of writes, then hand tests
// assumes pin_pads stands for the board
`timescale 1ns/100ps
module test_gpio_port;
   import gpio_port_pkg::*;
   typedef struct {logic [11:0] a; logic [7:0] d, oe, o, pu;} row_t;
   logic SYS_CLK_I, RESET_N_I, PSEL_I, PENABLE_I, PWRITE_I, SLEEP_I;
   logic PREADY_O, PSLVERR_O, err;
   logic [3:0] PSTRB_I = 4'hF;
   logic [11:0] PADDR_I;
   logic [31:0] PWDATA_I, PRDATA_O, q;
   logic [7:0] PIN_I, PIN_O, PIN_OE_O, PULLUP_ON_O, WAKE_EDGE_FLAG_O;
   logic [7:0] EXT_IRQ_ENABLE_I, acc, ext = 8'h33;
   int n_mismatch = 0, samples_checked = 0;
   row_t rows [6] = '{'{DIRECTION_OFS, 8'h0F, 8'h0F, 8'h00, 8'h00},
      '{OUTPUT_VALUE_OFS, 8'hA5, 8'h0F, 8'hA5, 8'h00},
      '{PULLUP_ENABLE_OFS, 8'h3C, 8'h0F, 8'hA5, 8'h3C},
      '{PIN_INPUT_OFS, 8'h0F, 8'h0F, 8'hAA, 8'h3C},
      '{PIN_INPUT_OFS, 8'h00, 8'h0F, 8'hAA, 8'h3C},
      '{DIRECTION_OFS, 8'hF0, 8'hF0, 8'hAA, 8'h3C}};
   gpio_port DUT (.*);
   pin_pads pads (.drv_i(PIN_O), .oe_i(PIN_OE_O), .ext_i(ext), .pad_o(PIN_I));
   // ======================
   // apb transfer held until pready; each takes three cycles, so
   // back-to-back transfers are three cycles apart
   task automatic bus(input logic w, input logic [11:0] a, logic [7:0] d);
      @(posedge SYS_CLK_I);
      PSEL_I <= 1'b1;
      PWRITE_I <= w;
      PADDR_I <= a;
      PWDATA_I <= {24'h000000, d};
      @(posedge SYS_CLK_I);
      PENABLE_I <= 1'b1;
      do @(posedge SYS_CLK_I); while (PREADY_O !== 1'b1);
      q = PRDATA_O;
      err = PSLVERR_O;
      PSEL_I <= 1'b0;
      PENABLE_I <= 1'b0;
   endtask : bus
   task automatic chk(input string nm, input logic [31:0] s, e);
      samples_checked++;
      if (s !== e) begin
         n_mismatch++;
         $display("BAD %s expected %h seen %h", nm, e, s);
      end
   endtask : chk
   task automatic wrap_up;
      $display("compares %0d mismatches %0d", samples_checked, n_mismatch);
      if (n_mismatch == 0 && samples_checked > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask : wrap_up
   // clock and watchdog
   initial begin
      SYS_CLK_I = 1'b0;
      forever #25 SYS_CLK_I = ~SYS_CLK_I;
   end
   initial begin
      repeat (3000) @(posedge SYS_CLK_I);
      n_mismatch++;
      wrap_up;
   end
   // main sequence
   initial begin
      {RESET_N_I, PSEL_I, PENABLE_I, PWRITE_I, SLEEP_I} = '0;
      {PADDR_I, PWDATA_I, EXT_IRQ_ENABLE_I} = '0;
      repeat (5) @(posedge SYS_CLK_I);
      RESET_N_I <= 1'b1;
      foreach (rows[i]) begin
         bus(1'b1, rows[i].a, rows[i].d);
         @(negedge SYS_CLK_I);
         chk("oe", PIN_OE_O, rows[i].oe);
         chk("out", PIN_O, rows[i].o);
         chk("pull", PULLUP_ON_O, rows[i].pu);
      end
      bus(1'b0, PIN_INPUT_OFS, 8'h00);
      chk("pins", q, 8'hF0 & 8'hAA | 8'h0F & ext);
      $display("table done");
      bus(1'b1, PORT_CONTROL_OFS, 8'h01);
      bus(1'b1, DIRECTION_OFS, 8'hFF);
      @(negedge SYS_CLK_I);
      chk("bbm hold", PIN_OE_O, 8'hF0);
      @(negedge SYS_CLK_I);
      chk("bbm on", PIN_OE_O, 8'hFF);
      bus(1'b1, DIRECTION_OFS, 8'h0F);
      @(negedge SYS_CLK_I);
      chk("bbm off", PIN_OE_O, 8'h0F);
      bus(1'b0, DIRECTION_OFS, 8'h00);
      chk("dir rd", q, 8'h0F);
      chk("mapped err", err, 1'b0);
      bus(1'b0, 12'h020, 8'h00);
      chk("unmapped", q, 32'h0);
      chk("unmapped err", err, 1'b1);
      bus(1'b1, OUTPUT_VALUE_OFS, 8'h0F);
      bus(1'b0, PIN_INPUT_OFS, 8'h00);
      chk("readback", q, 8'h0F | 8'hF0 & ext);
      bus(1'b1, DIRECTION_OFS, 8'h00);
      bus(1'b1, SENSE_CONTROL_OFS, 8'hFF);
      SLEEP_I <= 1'b1;
      EXT_IRQ_ENABLE_I <= 8'h01;
      bus(1'b0, PIN_INPUT_OFS, 8'h00);
      chk("clamp", q, ext & 8'h01);
      SLEEP_I <= 1'b0;
      acc = '0;
      repeat (4) begin
         @(negedge SYS_CLK_I);
         acc |= WAKE_EDGE_FLAG_O;
      end
      chk("wake", acc, ext & 8'hFE);
      bus(1'b1, PULLUP_ENABLE_OFS, 8'hFF);
      bus(1'b1, DIRECTION_OFS, 8'hFF);
      RESET_N_I <= 1'b0;
      @(negedge SYS_CLK_I);
      chk("rst oe", PIN_OE_O, 8'h00);
      chk("rst pull", PULLUP_ON_O, 8'h00);
      repeat (2) @(posedge SYS_CLK_I);
      RESET_N_I <= 1'b1;
      bus(1'b0, PULLUP_ENABLE_OFS, 8'h00);
      chk("rst clr", q, 32'h0);
      $display("hand tests done");
      wrap_up;
   end
endmodule : test_gpio_port
bind gpio_port gpio_port_properties #(.WIDTH(WIDTH)) props (.*);
